// ---- rtl/phy_link_pkg.sv ----
// Constants, encodings and timing for the link power and mode control block
// Summary of operation
// - Transmit at S100, S200, S400, S400B or S800
// - Transmit word width follows speed and protocol
// - Receive words go to link and repeat
// - Protocol select picks legacy or new interface
// - Protocol low disables BOSS arbitration and narrows the word path at S100 and S200
// - Per-port cable mode chosen automatically
// - On legacy ports pair A sets speed, pair B bias
// - Force-strobe high restricts port to legacy
// - Power-class straps default self-ID bits
// - Contender bit set only by software write
// - Indicator alone governs the link interface state
// - Inactive only after low past reset time
// - Reset state: outputs zero, request ignored
// - Past disable time also stop interface clock
// - Repeating continues in reset or disabled state
// - Indicator active again reinitializes the interface
// - Hardware reset holds interface disabled
// - Wake square wave on event while inactive
// - Wake stops when active or bus reset
// - Power-up wake pulse for power class 0-4
// - Straps load the power class field
package phy_link_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000; // 200 MHz local clock
	localparam int INACT_RESET_NS = 2600; // Indicator low time before reset state
	localparam int INACT_DISABLE_NS = 26000; // Indicator low time before disabled state
	localparam int POWERUP_WAKE_US = 167; // Power-up wake duration
	localparam int WAKE_HALF_NS = 100; // Half period of the wake square wave
	// Least times round up, longest time rounds down
	localparam int INACT_RESET_CYC = (INACT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INACT_DISABLE_CYC =
		(INACT_DISABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POWERUP_WAKE_CYC = (POWERUP_WAKE_US * 1000000) / CLK_PERIOD_PS;
	localparam int WAKE_HALF_CYC = (WAKE_HALF_NS * 1000) / CLK_PERIOD_PS;

	// ------------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00; // Control, read/write
	localparam logic [7:0] REG_STATUS = 8'h04; // Status, read only
	localparam logic [7:0] REG_SPEED = 8'h08; // Transmit speed, read/write
	localparam int CTRL_LINK_ACTIVE_CTRL_BIT = 0; // Link-active control bit
	localparam int CTRL_CONTENDER = 1; // Resource manager contender
	localparam int CTRL_INT_WAKE = 2; // PHY interrupt counts as wake event
	localparam int CTRL_PCLASS_LSB = 4; // Power class field
	localparam int STAT_STATE_LSB = 0; // Link interface state
	localparam int STAT_WAKE = 2; // Wake output active
	localparam int STAT_ACTIVE = 3; // Indicator considered active
	localparam int STAT_STRAP_LSB = 4; // Power class straps as captured
	localparam logic [2:0] PCLASS_WAKE_MAX = 3'h4; // Highest class with power-up wake

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		LINK_DISABLED = 2'b00,
		LINK_RESET = 2'b01,
		LINK_NORMAL = 2'b10
	} link_state_t;

	typedef enum logic [2:0] {
		SPD_S100 = 3'b000,
		SPD_S200 = 3'b001,
		SPD_S400 = 3'b010,
		SPD_S400B = 3'b011,
		SPD_S800 = 3'b100
	} speed_t;

	localparam logic [1:0] CTL_IDLE = 2'h0; // Control lines idle
	localparam logic [1:0] CTL_RECEIVE = 2'h2; // Control lines mark receive data
	localparam logic [1:0] CTL_TRANSMIT = 2'h3; // Link drives transmit data
	localparam logic [7:0] MASK_2BIT = 8'hC0; // Two-bit path uses the top lanes
	localparam logic [7:0] MASK_4BIT = 8'hF0; // Four-bit path
	localparam logic [7:0] MASK_8BIT = 8'hFF; // Eight-bit path

endpackage

// ---- rtl/phy_link_power_and_mode_control.sv ----
// Link power, interface mode and data path control of the three-port physical layer
`timescale 1ns/10ps

module phy_link_power_and_mode_control
#(
	parameter int DISABLE_CYCLES = phy_link_pkg::INACT_DISABLE_CYC,
	parameter int POWERUP_CYCLES = phy_link_pkg::POWERUP_WAKE_CYC
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic phy_link_protocol_sel,
	input wire logic link_power_indicator,
	input wire logic link_request_in,
	input wire logic [1:0] link_ctl_in,
	input wire logic [7:0] link_data_in,
	output logic [1:0] phy_link_control_lines,
	output logic [7:0] phy_data_out,
	output logic link_clk_out,
	output logic link_wake_out,
	output logic arb_request,
	input wire logic force_strobe_port0,
	input wire logic force_strobe_port1,
	input wire logic force_strobe_port2,
	input wire logic [2:0] peer_is_beta,
	input wire logic [2:0] port_active,
	input wire logic [5:0] pair_a_speed,
	input wire logic [2:0] pair_b_bias,
	input wire logic [2:0] rx_speed,
	input wire logic [1:0] rx_port,
	input wire logic rx_valid,
	input wire logic [7:0] rx_word,
	input wire logic link_on_packet,
	input wire logic phy_interrupt,
	input wire logic cable_bus_reset,
	input wire logic power_class_pin0,
	input wire logic power_class_pin1,
	input wire logic power_class_pin2,
	output logic [2:0] tx_speed,
	output logic [7:0] tx_word,
	output logic tx_valid,
	output logic [2:0] port_beta_mode,
	output logic boss_arb_enable,
	output logic [5:0] next_packet_speed,
	output logic [2:0] remote_bias_seen,
	output logic [7:0] repeat_word,
	output logic [2:0] repeat_enable,
	output logic bus_reset_req,
	output logic sid_link_active,
	output logic sid_contender,
	output logic [2:0] sid_power_class
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		phy_link_pkg::link_state_t lstate; // Link interface state
		logic [15:0] low_cnt; // Cycles the indicator has been low
		logic pclk; // Interface clock
		logic [1:0] ctl; // Control lines to the link
		logic [7:0] dout; // Data lines to the link
		logic arb_req; // Link request passed to arbitration
		logic wake_pend; // Wake event pending
		logic pwr_on; // Power-up wake window running
		logic [15:0] pwr_cnt; // Power-up window counter
		logic [15:0] wake_cnt; // Square wave half period counter
		logic wake_sq; // Square wave level
		logic strap_done; // Straps captured after reset release
		logic [2:0] strap_pc; // Captured strap levels
		logic [2:0] pclass; // Power class field
		logic link_active_ctrl_bit; // Link-active control bit
		logic contender; // Contender bit
		logic int_wake_en; // PHY interrupt wake enable
		logic [2:0] tx_spd; // Requested transmit speed
		logic [7:0] tx_w; // Transmit word to the serializer
		logic tx_v; // Transmit word valid
		logic [2:0] beta; // Per-port beta signalling
		logic boss; // BOSS arbitration enable
		logic [5:0] nspd; // Next packet speed per port
		logic [2:0] bias; // Remote bias seen per port
		logic [7:0] rep_w; // Repeated word
		logic [2:0] rep_en; // Ports repeating
		logic bus_rst; // Bus reset request pulse
		logic sid_la; // Self-ID link-active flag
		logic [7:0] a_addr; // Latched bus address
		logic a_wr; // Latched write
		logic a_sel; // Data phase pending
		logic [31:0] rdata; // Read data
	} state_t;

	state_t st;
	state_t next_st;

	// Working signals for the combinational process
	logic ind_high;
	logic llc_active;
	logic int_wake;
	logic wake_set;
	logic wake_clr;
	logic bus_rst_evt;
	logic [7:0] tx_mask;
	logic [7:0] rx_mask;
	logic [2:0] force_strobe;
	logic [2:0] src_port;

	// ------------------------------------------------------------------
	// Word width of the parallel path
	// ------------------------------------------------------------------
	// Legacy protocol narrows the path at low speeds, the newer one is always eight bits
	function automatic logic [7:0] width_mask(input logic [2:0] spd, input logic newer);
		logic [7:0] m;
		m = phy_link_pkg::MASK_8BIT;
		if (!newer)
		begin
			case (spd)
				phy_link_pkg::SPD_S100: m = phy_link_pkg::MASK_2BIT;
				phy_link_pkg::SPD_S200: m = phy_link_pkg::MASK_4BIT;
				default: m = phy_link_pkg::MASK_8BIT;
			endcase
		end
		return m;
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		force_strobe = {force_strobe_port2, force_strobe_port1, force_strobe_port0};
		ind_high = link_power_indicator;
		next_st.bus_rst = 1'b0;

		// Low time counter, cleared while the indicator is high; saturates
		if (ind_high)
		begin
			next_st.low_cnt = '0;
		end
		else if (st.low_cnt != 16'hFFFF)
		begin
			next_st.low_cnt = st.low_cnt + 16'h0001;
		end

		// Interface state follows the indicator only; the control bit plays no part
		case (st.lstate)
			phy_link_pkg::LINK_NORMAL:
			begin
				if (!ind_high && st.low_cnt > 16'(DISABLE_CYCLES))
				begin
					next_st.lstate = phy_link_pkg::LINK_DISABLED;
				end
				else if (!ind_high && st.low_cnt > 16'(phy_link_pkg::INACT_RESET_CYC))
				begin
					next_st.lstate = phy_link_pkg::LINK_RESET;
				end
			end
			phy_link_pkg::LINK_RESET:
			begin
				if (ind_high)
				begin
					next_st.lstate = phy_link_pkg::LINK_NORMAL;
				end
				else if (st.low_cnt > 16'(DISABLE_CYCLES))
				begin
					next_st.lstate = phy_link_pkg::LINK_DISABLED;
				end
			end
			default:
			begin
				// Coming back from disabled forces a bus reset so self-ID is re-sent
				if (ind_high)
				begin
					next_st.lstate = phy_link_pkg::LINK_NORMAL;
					next_st.bus_rst = 1'b1;
				end
			end
		endcase

		// Interface clock keeps running unless disabled
		if (next_st.lstate == phy_link_pkg::LINK_DISABLED)
		begin
			next_st.pclk = 1'b0;
		end
		else
		begin
			next_st.pclk = ~st.pclk;
		end

		// Transmit path from the link, width chosen by speed and protocol
		tx_mask = width_mask(st.tx_spd, phy_link_protocol_sel);
		rx_mask = width_mask(rx_speed, phy_link_protocol_sel);
		next_st.tx_w = '0;
		next_st.tx_v = 1'b0;
		next_st.arb_req = 1'b0;
		next_st.ctl = phy_link_pkg::CTL_IDLE;
		next_st.dout = '0;
		if (next_st.lstate == phy_link_pkg::LINK_NORMAL && st.lstate == phy_link_pkg::LINK_NORMAL)
		begin
			next_st.arb_req = link_request_in;
			if (link_ctl_in == phy_link_pkg::CTL_TRANSMIT)
			begin
				next_st.tx_w = link_data_in & tx_mask;
				next_st.tx_v = 1'b1;
			end
			if (rx_valid)
			begin
				next_st.ctl = phy_link_pkg::CTL_RECEIVE;
				next_st.dout = rx_word & rx_mask;
			end
		end
		// Otherwise outputs sit at zero and the request is dropped

		// Repeating on the other active ports goes on in every interface state
		src_port = 3'h0;
		if (rx_valid)
		begin
			src_port[rx_port] = 1'b1;
		end
		next_st.rep_w = rx_valid ? rx_word : 8'h00;
		next_st.rep_en = rx_valid ? (port_active & ~src_port) : 3'h0;

		// Cable side modes; forced ports never use beta signalling
		next_st.beta = peer_is_beta & ~force_strobe;
		next_st.boss = phy_link_protocol_sel;
		for (int p = 0; p < 3; p++)
		begin
			// Legacy arbitration reads speed from pair A and bias from pair B
			if (next_st.beta[p])
			begin
				next_st.nspd[2 * p +: 2] = st.nspd[2 * p +: 2];
				next_st.bias[p] = st.bias[p];
			end
			else
			begin
				next_st.nspd[2 * p +: 2] = pair_a_speed[2 * p +: 2];
				next_st.bias[p] = pair_b_bias[p];
			end
		end

		// Straps are sampled once, one clock after reset release
		if (!st.strap_done)
		begin
			next_st.strap_done = 1'b1;
			next_st.strap_pc = {power_class_pin2, power_class_pin1, power_class_pin0};
			next_st.pclass = {power_class_pin2, power_class_pin1, power_class_pin0};
			next_st.pwr_on = ({power_class_pin2, power_class_pin1, power_class_pin0}
				<= phy_link_pkg::PCLASS_WAKE_MAX);
			next_st.pwr_cnt = '0;
		end

		// Wake logic: the link is inactive if the indicator is inactive or the bit is clear
		llc_active = (st.lstate == phy_link_pkg::LINK_NORMAL) && st.link_active_ctrl_bit;
		int_wake = st.int_wake_en && phy_interrupt;
		bus_rst_evt = st.bus_rst || cable_bus_reset;
		wake_set = !llc_active && (link_on_packet || int_wake);
		wake_clr = llc_active || (bus_rst_evt && !int_wake);
		// A new event in the clearing cycle still wins
		next_st.wake_pend = wake_set || (st.wake_pend && !wake_clr);
		if (st.pwr_on && st.strap_done)
		begin
			if (llc_active || st.pwr_cnt >= 16'(POWERUP_CYCLES - 1))
			begin
				next_st.pwr_on = 1'b0;
			end
			else
			begin
				next_st.pwr_cnt = st.pwr_cnt + 16'h0001;
			end
		end

		// Square wave while any wake cause stands, low otherwise
		if (st.wake_pend || (st.pwr_on && st.strap_done))
		begin
			if (st.wake_cnt >= 16'(phy_link_pkg::WAKE_HALF_CYC - 1))
			begin
				next_st.wake_cnt = '0;
				next_st.wake_sq = ~st.wake_sq;
			end
			else
			begin
				next_st.wake_cnt = st.wake_cnt + 16'h0001;
			end
		end
		else
		begin
			next_st.wake_cnt = '0;
			next_st.wake_sq = 1'b0;
		end

		// Self-ID flag reflects whether the link can be reached
		next_st.sid_la = llc_active;

		// ------------------------------------------------------------------
		// Bus slave: zero wait states, always OKAY
		// ------------------------------------------------------------------
		next_st.a_sel = 1'b0;
		next_st.rdata = '0;
		// Write data phase
		if (st.a_sel && st.a_wr)
		begin
			if (st.a_addr == phy_link_pkg::REG_CTRL)
			begin
				next_st.link_active_ctrl_bit = hwdata[phy_link_pkg::CTRL_LINK_ACTIVE_CTRL_BIT];
				next_st.contender = hwdata[phy_link_pkg::CTRL_CONTENDER];
				next_st.int_wake_en = hwdata[phy_link_pkg::CTRL_INT_WAKE];
				next_st.pclass = hwdata[phy_link_pkg::CTRL_PCLASS_LSB +: 3];
			end
			else if (st.a_addr == phy_link_pkg::REG_SPEED)
			begin
				next_st.tx_spd = hwdata[2:0];
			end
		end
		// Address phase; read data is registered so it stands in the data phase
		if (hsel && htrans[1] && hready)
		begin
			next_st.a_sel = 1'b1;
			next_st.a_wr = hwrite;
			next_st.a_addr = haddr[7:0];
			if (!hwrite)
			begin
				if (haddr[7:0] == phy_link_pkg::REG_CTRL)
				begin
					next_st.rdata[phy_link_pkg::CTRL_LINK_ACTIVE_CTRL_BIT] = st.link_active_ctrl_bit;
					next_st.rdata[phy_link_pkg::CTRL_CONTENDER] = st.contender;
					next_st.rdata[phy_link_pkg::CTRL_INT_WAKE] = st.int_wake_en;
					next_st.rdata[phy_link_pkg::CTRL_PCLASS_LSB +: 3] = st.pclass;
				end
				else if (haddr[7:0] == phy_link_pkg::REG_STATUS)
				begin
					next_st.rdata[phy_link_pkg::STAT_STATE_LSB +: 2] = st.lstate;
					next_st.rdata[phy_link_pkg::STAT_WAKE] = st.wake_pend || st.pwr_on;
					next_st.rdata[phy_link_pkg::STAT_ACTIVE] =
						(st.lstate == phy_link_pkg::LINK_NORMAL);
					next_st.rdata[phy_link_pkg::STAT_STRAP_LSB +: 3] = st.strap_pc;
				end
				else if (haddr[7:0] == phy_link_pkg::REG_SPEED)
				begin
					next_st.rdata[2:0] = st.tx_spd;
				end
				// Unmapped addresses read as zero
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Hardware reset leaves the interface disabled and all controls cleared
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= '0;
			st.lstate <= phy_link_pkg::LINK_DISABLED;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs straight from the state register; bus ready and response are tied off
	// ------------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;
	assign phy_link_control_lines = st.ctl;
	assign phy_data_out = st.dout;
	assign link_clk_out = st.pclk;
	assign link_wake_out = st.wake_sq;
	assign arb_request = st.arb_req;
	assign tx_speed = st.tx_spd;
	assign tx_word = st.tx_w;
	assign tx_valid = st.tx_v;
	assign port_beta_mode = st.beta;
	assign boss_arb_enable = st.boss;
	assign next_packet_speed = st.nspd;
	assign remote_bias_seen = st.bias;
	assign repeat_word = st.rep_w;
	assign repeat_enable = st.rep_en;
	assign bus_reset_req = st.bus_rst;
	assign sid_link_active = st.sid_la;
	assign sid_contender = st.contender;
	assign sid_power_class = st.pclass;

endmodule

// ---- test/phy_link_power_and_mode_control_asserts.sv ----
// Port checks of the link power and mode control block
`timescale 1ns/10ps

module phy_link_power_and_mode_control_asserts
#(parameter int DISABLE_CYCLES = 5200)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic phy_link_protocol_sel,
	input wire logic link_power_indicator,
	input wire logic link_request_in,
	input wire logic link_on_packet,
	input wire logic rx_valid,
	input wire logic [1:0] rx_port,
	input wire logic [7:0] rx_word,
	input wire logic [2:0] port_active,
	input wire logic [1:0] phy_link_control_lines,
	input wire logic [7:0] phy_data_out,
	input wire logic link_clk_out,
	input wire logic link_wake_out,
	input wire logic arb_request,
	input wire logic boss_arb_enable,
	input wire logic [7:0] repeat_word,
	input wire logic [2:0] repeat_enable,
	input wire logic bus_reset_req
);
	// ----------
	// Low time tracker
	// ----------
	// Low run length; reset counts as a long low
	logic [11:0] low_cnt;

	default clocking main_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Saturates so a long low never wraps
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			low_cnt <= 12'hFFF;
		else if (link_power_indicator)
			low_cnt <= 12'h000;
		else if (low_cnt != 12'hFFF)
			low_cnt <= low_cnt + 12'h001;

	// ----------
	// Checks
	// ----------
	AST_HW_RESET: assert property (disable iff (1'b0)
		!hresetn |-> !link_clk_out && phy_link_control_lines == 2'h0)
		else $error("Interface live in reset");
	AST_SHORT_LOW: assert property (
		link_power_indicator ##1 (!link_power_indicator) [*8] ##0 link_request_in
		|=> arb_request)
		else $error("Short low left the normal state");
	AST_RESET_ZERO: assert property (low_cnt > 12'h212
		|-> phy_link_control_lines == 2'h0 && phy_data_out == 8'h00 && !arb_request)
		else $error("Outputs not zero in reset");
	AST_RESET_CLK: assert property (
		low_cnt > 12'h212 && low_cnt < DISABLE_CYCLES - 10 |-> link_clk_out != $past(link_clk_out))
		else $error("Interface clock stopped in reset state");
	AST_DISABLE_CLK: assert property (low_cnt > DISABLE_CYCLES + 10 |-> !link_clk_out)
		else $error("Clock runs when disabled");
	AST_BUS_RESET: assert property (
		$rose(link_power_indicator) && low_cnt > DISABLE_CYCLES + 10 |-> ##[1:3] bus_reset_req)
		else $error("No bus reset after disabled");
	AST_WAKE_START: assert property (
		link_on_packet && low_cnt > 12'h212 |-> ##[1:22] link_wake_out)
		else $error("Wake output did not start");
	AST_REPEAT: assert property (rx_valid |=> repeat_word == $past(rx_word) &&
		repeat_enable == ($past(port_active) & ~(3'h1 << $past(rx_port))))
		else $error("Received word not repeated");
	AST_BOSS_OFF: assert property (
		!phy_link_protocol_sel ##1 !phy_link_protocol_sel |-> !boss_arb_enable)
		else $error("BOSS on in legacy mode");
endmodule

bind phy_link_power_and_mode_control phy_link_power_and_mode_control_asserts
	#(.DISABLE_CYCLES(DISABLE_CYCLES)) checks (.*);

// ---- test/link_ctrl_model.sv ----
// Behavioural link-layer controller on the parallel interface
`timescale 1ns/10ps

module link_ctrl_model
(
	input wire logic hclk,
	input wire logic power_on,
	input wire logic send,
	input wire logic [7:0] send_byte,
	output logic link_power_indicator,
	output logic link_request_in,
	output logic [1:0] link_ctl_in,
	output logic [7:0] link_data_in
);
	// Idle, unpowered link at time zero
	initial
	begin
		link_power_indicator = 1'b0;
		link_request_in = 1'b0;
		link_ctl_in = 2'h0;
		link_data_in = 8'h00;
	end

	// Launched just after the edge, a cycle late
	always @(posedge hclk)
	begin
		link_power_indicator <= power_on;
		link_request_in <= send;
		if (send)
		begin
			link_ctl_in <= phy_link_pkg::CTL_TRANSMIT;
			link_data_in <= send_byte;
		end
		else
		begin
			// Released data toggles, so stale bytes show
			link_ctl_in <= phy_link_pkg::CTL_IDLE;
			link_data_in <= ~link_data_in;
		end
	end
endmodule

// ---- test/phy_link_power_and_mode_control_bench.sv ----
// Self-checking bench of the link power and mode control block
`timescale 1ns/10ps

module phy_link_power_and_mode_control_bench;
	// ----------
	// Signals
	// ----------
	localparam int DIS = 2000; // Short disable time, above reset time
	logic hclk = 1'b0;
	logic hresetn = 1'b1; // Dropped at time zero
	logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0, link_ctl_in, phy_link_control_lines, rx_port = 2'h0;
	logic phy_link_protocol_sel = 1'b0, link_power_indicator, link_request_in;
	logic [7:0] link_data_in, phy_data_out, rx_word = 8'h00, tx_word, repeat_word;
	logic link_clk_out, link_wake_out, arb_request, rx_valid = 1'b0, link_on_packet = 1'b0;
	logic cable_bus_reset = 1'b0, tx_valid, boss_arb_enable, bus_reset_req;
	logic sid_link_active, sid_contender, pwr = 1'b0, snd = 1'b0;
	logic [2:0] fs = 3'h4; // Port 2 strobe forced high, so held to legacy signalling
	logic [2:0] peer_is_beta = 3'h0, port_active = 3'h0, pair_b_bias = 3'h0, pc = 3'h0;
	logic [2:0] rx_speed = 3'h0, tx_speed, port_beta_mode, remote_bias_seen, repeat_enable;
	logic [2:0] sid_power_class;
	logic [5:0] pair_a_speed = 6'h00, next_packet_speed;
	logic [7:0] sbyte = 8'h00;
	int n_mismatch = 0, check_count = 0;

	always #2.5 hclk = ~hclk;

	phy_link_power_and_mode_control #(.DISABLE_CYCLES(DIS), .POWERUP_CYCLES(50)) uut (.*,
		.hsize(3'h2), .hready(hreadyout), .phy_interrupt(1'b0),
		.force_strobe_port0(fs[0]), .force_strobe_port1(fs[1]), .force_strobe_port2(fs[2]),
		.power_class_pin0(pc[0]), .power_class_pin1(pc[1]), .power_class_pin2(pc[2]));

	link_ctrl_model link (.hclk, .power_on(pwr), .send(snd), .send_byte(sbyte),
		.link_power_indicator, .link_request_in, .link_ctl_in, .link_data_in);

	// ----------
	// Shared tasks
	// ----------
	// n edges, then the falling edge
	task cyc(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Reads the interface state field and compares it
	task chk_state(input string nm, input logic [1:0] e);
		logic [31:0] d;
		bus(1'b0, phy_link_pkg::REG_STATUS, 32'h0, d);
		chk(nm, 32'(e), 32'(d[1:0]));
	endtask

	// Hardware reset with the given straps
	task rst(input logic [2:0] c);
		pc <= c;
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		cyc(1);
	endtask

	// Holds a phase until hready is high; data read before that edge
	task wait_ready(output logic [31:0] rd);
		int n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1 && n < 100)
		begin
			@(negedge hclk);
			r = hreadyout;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end
		if (r !== 1'b1)
			n_mismatch++;
	endtask

	// One single word transfer
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready(rd);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(rd);
	endtask

	// Counts wake high samples over n cycles
	task wake_count(input int n, output int hi);
		hi = 0;
		repeat (n)
		begin
			@(negedge hclk);
			if (link_wake_out === 1'b1)
				hi++;
		end
	endtask

	// ----------
	// Scenarios
	// ----------
	task t_regs;
		logic [31:0] d;
		cyc(60);
		chk("sid_power_class", 32'h6, 32'(sid_power_class));
		chk("wake_class6", 32'h0, 32'(link_wake_out));
		bus(1'b0, phy_link_pkg::REG_CTRL, 32'h0, d);
		chk("ctrl", 32'h60, d);
		chk("sid_contender", 32'h0, 32'(sid_contender));
		bus(1'b1, 8'h0C, 32'hFFFFFFFF, d);
		bus(1'b0, 8'h0C, 32'h0, d);
		chk("unmapped", 32'h0, d);
		bus(1'b1, phy_link_pkg::REG_CTRL, 32'h62, d);
		cyc(2);
		chk("sid_contender", 32'h1, 32'(sid_contender));
		for (int s = 0; s < 5; s++)
		begin
			bus(1'b1, phy_link_pkg::REG_SPEED, 32'(s), d);
			cyc(2);
			chk("tx_speed", 32'(s), 32'(tx_speed));
		end
		$display("registers done");
	endtask

	task t_pwrup;
		int a, b;
		@(posedge hclk);
		rst(3'h2);
		wake_count(60, a);
		wake_count(50, b);
		chk("wake_early", 32'h1, 32'(a > 0));
		chk("wake_late", 32'h0, 32'(b));
		$display("power-up wake done");
	endtask

	task t_power;
		logic [31:0] d;
		int n;
		@(posedge hclk);
		pwr <= 1'b1;
		snd <= 1'b1;
		cyc(4);
		chk_state("state_up", 2'h2);
		@(posedge hclk);
		pwr <= 1'b0;
		cyc(200);
		chk_state("state_short", 2'h2);
		cyc(340);
		chk_state("state_reset", 2'h1);
		chk("arb_ignored", 32'h0, 32'(arb_request));
		@(posedge hclk);
		rx_valid <= 1'b1;
		rx_word <= 8'h3C;
		rx_port <= 2'h1;
		port_active <= 3'h7;
		cyc(2);
		chk("repeat_word", 32'h3C, 32'(repeat_word));
		chk("repeat_enable", 32'h5, 32'(repeat_enable));
		chk("data_zero", 32'h0, 32'(phy_data_out));
		@(posedge hclk);
		rx_valid <= 1'b0;
		link_on_packet <= 1'b1;
		@(posedge hclk);
		link_on_packet <= 1'b0;
		n = 0;
		while (link_wake_out !== 1'b1 && n < 25)
		begin
			@(negedge hclk);
			n++;
		end
		chk("wake_on", 32'h1, 32'(link_wake_out));
		n = 0;
		while (link_wake_out === 1'b1 && n < 40)
		begin
			n++;
			@(negedge hclk);
		end
		chk("wake_half", 32'(phy_link_pkg::WAKE_HALF_CYC), 32'(n));
		@(posedge hclk);
		cable_bus_reset <= 1'b1;
		@(posedge hclk);
		cable_bus_reset <= 1'b0;
		cyc(2);
		wake_count(40, n);
		chk("wake_bus_reset", 32'h0, 32'(n));
		cyc(DIS);
		chk_state("state_disabled", 2'h0);
		chk("clk_stopped", 32'h0, 32'(link_clk_out));
		@(posedge hclk);
		pwr <= 1'b1;
		n = 0;
		repeat (10)
		begin
			@(negedge hclk);
			if (bus_reset_req === 1'b1)
				n++;
		end
		chk("bus_reset", 32'h1, 32'(n));
		chk_state("state_back", 2'h2);
		bus(1'b1, phy_link_pkg::REG_CTRL, 32'h1, d);
		cyc(2);
		chk("sid_link_active", 32'h1, 32'(sid_link_active));
		$display("link power done");
	endtask

	task t_wake;
		logic [31:0] d;
		int n;
		bus(1'b1, phy_link_pkg::REG_CTRL, 32'h0, d);
		@(posedge hclk);
		link_on_packet <= 1'b1;
		@(posedge hclk);
		link_on_packet <= 1'b0;
		wake_count(25, n);
		chk("wake_link_active_ctrl_bit_off", 32'h1, 32'(n > 0));
		bus(1'b1, phy_link_pkg::REG_CTRL, 32'h1, d);
		cyc(2);
		wake_count(30, n);
		chk("wake_active", 32'h0, 32'(n));
		$display("wake done");
	endtask

	task t_data;
		logic [31:0] d;
		bus(1'b1, phy_link_pkg::REG_SPEED, 32'(phy_link_pkg::SPD_S100), d);
		@(posedge hclk);
		phy_link_protocol_sel <= 1'b1;
		sbyte <= 8'hA5;
		cyc(4);
		chk("tx_word_new", 32'hA5, 32'(tx_word));
		chk("tx_valid", 32'h1, 32'(tx_valid));
		chk("boss_on", 32'h1, 32'(boss_arb_enable));
		@(posedge hclk);
		phy_link_protocol_sel <= 1'b0;
		cyc(4);
		chk("tx_word_s100", 32'(8'hA5 & phy_link_pkg::MASK_2BIT), 32'(tx_word));
		chk("boss_off", 32'h0, 32'(boss_arb_enable));
		bus(1'b1, phy_link_pkg::REG_SPEED, 32'(phy_link_pkg::SPD_S200), d);
		cyc(3);
		chk("tx_word_s200", 32'(8'hA5 & phy_link_pkg::MASK_4BIT), 32'(tx_word));
		@(posedge hclk);
		rx_valid <= 1'b1;
		rx_word <= 8'hE7;
		cyc(3);
		chk("ctl_receive", 32'(phy_link_pkg::CTL_RECEIVE), 32'(phy_link_control_lines));
		chk("rx_s100", 32'(8'hE7 & phy_link_pkg::MASK_2BIT), 32'(phy_data_out));
		@(posedge hclk);
		rx_speed <= phy_link_pkg::SPD_S400;
		cyc(3);
		chk("rx_s400", 32'hE7, 32'(phy_data_out));
		@(posedge hclk);
		rx_valid <= 1'b0;
		peer_is_beta <= 3'h7;
		fs <= 3'h6;
		cyc(3);
		chk("beta_mode", 32'h1, 32'(port_beta_mode));
		@(posedge hclk);
		peer_is_beta <= 3'h0;
		pair_a_speed <= 6'h24;
		pair_b_bias <= 3'h5;
		cyc(3);
		chk("next_speed", 32'h24, 32'(next_packet_speed));
		chk("remote_bias", 32'h5, 32'(remote_bias_seen));
		$display("data path done");
	endtask

	// ----------
	// Sequence and verdict
	// ----------
	task end_of_test;
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		rst(3'h6);
		t_regs;
		t_pwrup;
		t_power;
		t_wake;
		t_data;
		end_of_test;
	end

	// Some six or seven times the run
	initial
	begin
		#100000;
		n_mismatch++;
		end_of_test;
	end
endmodule
